// File: core/cell_store_ctrl.sv
// data nonvolatile cell access controller: registers, sequencer and array
`timescale 1ns/1ps
module cell_store_ctrl
#(
    parameter int unsigned WRITE_TICKS = cell_store_pkg::WRITE_SLOW_TICKS
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic slow_clock,
    input wire logic [7:0] index_wdata,
    input wire logic index_we,
    input wire logic [7:0] byte_wdata,
    input wire logic byte_we,
    input wire logic [7:0] ctrl_wdata,
    input wire logic ctrl_we,
    input wire logic [7:0] ptr_low,
    input wire logic [7:0] ptr_high,
    input wire logic nvm_done_irq_enable,
    input wire logic global_irq_enable,
    input wire logic stack_full,
    input wire logic irq_ack,
    input wire logic low_power_entry,
    output logic [7:0] index_rdata,
    output logic [7:0] byte_rdata,
    output logic [7:0] ctrl_rdata,
    output logic nvm_done_irq_flag,
    output logic irq_request,
    output logic busy
);
    import cell_store_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // storage and registers

    logic [7:0] cells [CELL_COUNT];
    logic [INDEX_W-1:0] index_ff;
    logic [7:0] byte_ff;
    logic prog_en_ff;
    logic prog_go_ff;
    logic fetch_en_ff;
    logic fetch_go_ff;
    logic done_flag_ff;
    cell_state_t state_ff;
    logic [1:0] fetch_cnt_ff;
    logic [15:0] tick_cnt_ff;
    logic slow_s1_ff;
    logic slow_s2_ff;
    logic slow_s3_ff;
    logic slow_rise;
    logic ctrl_sel;
    logic fetch_start;
    logic prog_start;
    logic fetch_end;
    logic prog_end;
    logic abort;

    // indirect access only reaches the control register at sector 1, 40h
    assign ctrl_sel = ctrl_we && ptr_low == CTRL_OFFSET && ptr_high == CTRL_SECTOR;

    // trigger honoured only if enable was already set before this write
    assign prog_start = ctrl_sel && ctrl_wdata[BIT_PROG_GO] && prog_en_ff
        && state_ff == ST_IDLE;
    assign fetch_start = ctrl_sel && ctrl_wdata[BIT_FETCH_GO] && fetch_en_ff
        && state_ff == ST_IDLE && !prog_start;

    ////////////////////////////////////////////////////////////////////////////
    // slow clock synchroniser; the timer is asynchronous to sys_clk
    // the third flop only serves the edge detector, so only the second feeds logic

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            slow_s1_ff <= 1'b0;
            slow_s2_ff <= 1'b0;
            slow_s3_ff <= 1'b0;
        end
        else
        begin
            slow_s1_ff <= slow_clock;
            slow_s2_ff <= slow_s1_ff;
            slow_s3_ff <= slow_s2_ff;
        end
    end
    assign slow_rise = slow_s2_ff && !slow_s3_ff;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    // a read ends after fixed system cycles; a write waits for slow ticks
    assign abort = low_power_entry && state_ff != ST_IDLE;
    assign fetch_end = state_ff == ST_FETCH && fetch_cnt_ff == 2'(FETCH_CYCLES - 1);
    assign prog_end = state_ff == ST_PROG && slow_rise
        && tick_cnt_ff == 16'(WRITE_TICKS - 1);

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_ff <= ST_IDLE;
            fetch_cnt_ff <= 2'h0;
            tick_cnt_ff <= 16'h0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    fetch_cnt_ff <= 2'h0;
                    tick_cnt_ff <= 16'h0;
                    if (prog_start)
                        state_ff <= ST_PROG;
                    else if (fetch_start)
                        state_ff <= ST_FETCH;
                end
                ST_FETCH:
                begin
                    fetch_cnt_ff <= fetch_cnt_ff + 2'h1;
                    if (fetch_end || abort)
                        state_ff <= ST_IDLE;
                end
                ST_PROG:
                begin
                    if (slow_rise)
                        tick_cnt_ff <= tick_cnt_ff + 16'h1;
                    if (prog_end || abort)
                        state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register

    // enables follow every accepted control write; a trigger alone never sets them
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            prog_en_ff <= 1'b0;
            fetch_en_ff <= 1'b0;
        end
        else if (ctrl_sel)
        begin
            prog_en_ff <= ctrl_wdata[BIT_PROG_EN];
            fetch_en_ff <= ctrl_wdata[BIT_FETCH_EN];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            prog_go_ff <= 1'b0;
            fetch_go_ff <= 1'b0;
        end
        else
        begin
            // start and end never meet in one cycle: start needs the idle state
            if (prog_start)
                prog_go_ff <= 1'b1;
            else if (prog_end || abort)
                prog_go_ff <= 1'b0;
            if (fetch_start)
                fetch_go_ff <= 1'b1;
            else if (fetch_end || abort)
                fetch_go_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // index, byte and array

    // index and byte writes are dropped during a write so the stored cell stays coherent
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            index_ff <= '0;
        else if (index_we && state_ff != ST_PROG)
            index_ff <= index_wdata[INDEX_W-1:0];
    end

    // byte is only replaced by software or a completed read
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            byte_ff <= RESET_BYTE;
        else if (fetch_end && !abort)
            byte_ff <= cells[index_ff];
        else if (byte_we && state_ff != ST_PROG)
            byte_ff <= byte_wdata;
    end

    // array is not reset: it is the nonvolatile content
    always_ff @(posedge sys_clk)
    begin
        if (prog_end && !abort)
            cells[index_ff] <= byte_ff;
    end

    ////////////////////////////////////////////////////////////////////////////
    // write done flag and request

    // an aborted write still reports its end, so software never polls forever
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            done_flag_ff <= 1'b0;
        else if (prog_end || (abort && state_ff == ST_PROG))
            done_flag_ff <= 1'b1;
        else if (irq_ack)
            done_flag_ff <= 1'b0;
    end

    assign irq_request = done_flag_ff && nvm_done_irq_enable && global_irq_enable
        && !stack_full;
    assign nvm_done_irq_flag = done_flag_ff;
    assign busy = state_ff != ST_IDLE;
    assign index_rdata = {2'b00, index_ff};
    assign byte_rdata = byte_ff;
    assign ctrl_rdata = {4'h0, prog_en_ff, prog_go_ff, fetch_en_ff, fetch_go_ff};

    ////////////////////////////////////////////////////////////////////////////
    // checks

    chk_prog_gated: assert property (@(posedge sys_clk) disable iff (reset)
        (state_ff == ST_IDLE && $past(state_ff) == ST_IDLE && !$past(prog_en_ff)
        && !$past(reset)) |-> !(prog_go_ff && !$past(prog_go_ff)))
        else $error("write started without prior enable");
    chk_fetch_gated: assert property (@(posedge sys_clk) disable iff (reset)
        (fetch_start) |-> $past(fetch_en_ff) || fetch_en_ff)
        else $error("read started without enable");
    chk_fetch_clears: assert property (@(posedge sys_clk) disable iff (reset)
        (fetch_start && !low_power_entry) |=> ##2 !fetch_go_ff)
        else $error("read trigger not cleared in time");
    chk_prog_clears: assert property (@(posedge sys_clk) disable iff (reset)
        (prog_end) |=> !prog_go_ff && state_ff == ST_IDLE)
        else $error("write trigger not cleared at end");
    chk_done_sets: assert property (@(posedge sys_clk) disable iff (reset)
        (prog_end) |=> done_flag_ff)
        else $error("done flag not set at write end");
    chk_irq_gate: assert property (@(posedge sys_clk) disable iff (reset)
        irq_request |-> (done_flag_ff && global_irq_enable && !stack_full))
        else $error("request without all enables");
    chk_byte_holds: assert property (@(posedge sys_clk) disable iff (reset)
        (!fetch_end && !byte_we) |=> $stable(byte_ff))
        else $error("read byte changed spontaneously");
    chk_index_upper: assert property (@(posedge sys_clk) disable iff (reset)
        index_rdata[7:6] == 2'b00)
        else $error("index upper bits not zero");
    chk_abort_idle: assert property (@(posedge sys_clk) disable iff (reset)
        abort |=> state_ff == ST_IDLE && !prog_go_ff && !fetch_go_ff)
        else $error("operation survived low power entry");

    // invariants on state, triggers, the done flag, request gating, index and byte freezing, readback and the tick counter
    chk_irq_enable_gate: assert property (@(posedge sys_clk) disable iff (reset)
        irq_request |-> nvm_done_irq_enable)
        else $error("request without done interrupt enable");
    chk_reset_no_write: assert property (@(posedge sys_clk) disable iff (reset)
        $past(reset) |-> !prog_en_ff && !prog_go_ff)
        else $error("write permitted right after reset");
    chk_prog_rise_enabled: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(prog_go_ff) |-> $past(prog_en_ff))
        else $error("write trigger rose without prior enable");
    chk_fetch_rise_enabled: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(fetch_go_ff) |-> $past(fetch_en_ff))
        else $error("read trigger rose without prior enable");
    chk_busy_trigger: assert property (@(posedge sys_clk) disable iff (reset)
        busy |-> (prog_go_ff || fetch_go_ff))
        else $error("busy without a trigger bit");
    chk_idle_triggers: assert property (@(posedge sys_clk) disable iff (reset)
        !busy |-> (!prog_go_ff && !fetch_go_ff))
        else $error("trigger bit left set while idle");
    chk_single_op: assert property (@(posedge sys_clk) disable iff (reset)
        !(prog_go_ff && fetch_go_ff))
        else $error("both triggers active");
    chk_write_freeze: assert property (@(posedge sys_clk) disable iff (reset)
        state_ff == ST_PROG |=> $stable(index_ff))
        else $error("index changed during a write");
    chk_byte_blocked: assert property (@(posedge sys_clk) disable iff (reset)
        state_ff == ST_PROG |=> $stable(byte_ff))
        else $error("byte changed during a write");
    chk_flag_holds: assert property (@(posedge sys_clk) disable iff (reset)
        (done_flag_ff && !irq_ack) |=> done_flag_ff)
        else $error("done flag fell without service");
    chk_ack_clears: assert property (@(posedge sys_clk) disable iff (reset)
        (irq_ack && !prog_end && !abort) |=> !done_flag_ff)
        else $error("done flag not cleared by service");
    chk_ctrl_upper: assert property (@(posedge sys_clk) disable iff (reset)
        ctrl_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");
    chk_fetch_busy: assert property (@(posedge sys_clk) disable iff (reset)
        fetch_start |=> busy && fetch_go_ff)
        else $error("read did not start");
    chk_prog_busy: assert property (@(posedge sys_clk) disable iff (reset)
        prog_start |=> busy && prog_go_ff)
        else $error("write did not start");
    chk_tick_bound: assert property (@(posedge sys_clk) disable iff (reset)
        !(tick_cnt_ff > 16'(WRITE_TICKS)))
        else $error("write tick counter overran");
    chk_read_short: assert property (@(posedge sys_clk) disable iff (reset)
        fetch_start |=> ##2 !busy)
        else $error("read cycle too long");
endmodule

// File: core/cell_store_pkg.sv
// constants and types for the data nonvolatile cell access controller
package cell_store_pkg;
    localparam int unsigned CELL_COUNT = 64;
    localparam int unsigned INDEX_W = 6;
    localparam logic [7:0] CTRL_OFFSET = 8'h40;
    localparam logic [7:0] CTRL_SECTOR = 8'h01;
    localparam int unsigned BIT_PROG_EN = 3;
    localparam int unsigned BIT_PROG_GO = 2;
    localparam int unsigned BIT_FETCH_EN = 1;
    localparam int unsigned BIT_FETCH_GO = 0;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int unsigned WRITE_SLOW_TICKS = 64;
    localparam int unsigned FETCH_CYCLES = 2;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_PROG = 2'b10
    } cell_state_t;
endpackage

// File: sim/cpu_side_model.sv
// far side model: slow oscillator and interrupt service of the cpu
`timescale 1ns/1ps
module cpu_side_model
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic irq_request,
    output logic slow_clock,
    output logic irq_ack
);
    initial slow_clock = 1'h0;
    // steady from time zero, so every write sees a settled slow source
    always #37 slow_clock = ~slow_clock;
    ////////////////////////////////////////////////////////////////
    // one service pulse per request, then the flag must have fallen
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            irq_ack <= 1'h0;
        else
            irq_ack <= irq_request && !irq_ack;
    end
endmodule

// File: sim/test_cell_store_ctrl.sv
// self-checking bench for the cell access controller
`timescale 1ns/1ps
module test_cell_store_ctrl;
    import cell_store_pkg::*;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic slow_clock, irq_ack, nvm_done_irq_flag, irq_request, busy;
    logic index_we = 1'h0, byte_we = 1'h0, ctrl_we = 1'h0, low_power_entry = 1'h0;
    logic nvm_done_irq_enable = 1'h0, global_irq_enable = 1'h0, stack_full = 1'h0;
    logic [7:0] index_wdata = 8'h00, byte_wdata = 8'h00, ctrl_wdata = 8'h00;
    logic [7:0] ptr_low = 8'h40, ptr_high = 8'h01;
    logic [7:0] index_rdata, byte_rdata, ctrl_rdata;
    logic [7:0] mem [4];
    logic [5:0] adr [4];
    logic [7:0] exp_q [$];
    logic seen_go = 1'h0;
    int errors = 0, samples_checked = 0;
    always #5 sys_clk = ~sys_clk;
    cell_store_ctrl #(.WRITE_TICKS(2)) i_cell_store_ctrl (.sys_clk(sys_clk), .reset(reset),
        .slow_clock(slow_clock), .index_wdata(index_wdata), .index_we(index_we),
        .byte_wdata(byte_wdata), .byte_we(byte_we), .ctrl_wdata(ctrl_wdata),
        .ctrl_we(ctrl_we), .ptr_low(ptr_low), .ptr_high(ptr_high),
        .nvm_done_irq_enable(nvm_done_irq_enable), .global_irq_enable(global_irq_enable),
        .stack_full(stack_full), .irq_ack(irq_ack), .low_power_entry(low_power_entry),
        .index_rdata(index_rdata), .byte_rdata(byte_rdata), .ctrl_rdata(ctrl_rdata),
        .nvm_done_irq_flag(nvm_done_irq_flag), .irq_request(irq_request), .busy(busy));
    cpu_side_model i_cpu_side_model (.sys_clk(sys_clk), .reset(reset),
        .irq_request(irq_request), .slow_clock(slow_clock), .irq_ack(irq_ack));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one strobe, then a free edge so no signal is assigned twice at once
    task automatic wreg(input int s, input logic [7:0] d);
        @(posedge sys_clk);
        index_wdata <= d;
        byte_wdata <= d;
        ctrl_wdata <= d;
        index_we <= (s == 0);
        byte_we <= (s == 1);
        ctrl_we <= (s == 2);
        @(posedge sys_clk);
        index_we <= 1'h0;
        byte_we <= 1'h0;
        ctrl_we <= 1'h0;
    endtask
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (2) @(posedge sys_clk);
        while (busy !== 1'h0)
        begin
            @(posedge sys_clk);
            n++;
            if (n > 300)
            begin
                errors++;
                tally_and_finish();
            end
        end
        #1;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wreg(0, {2'h0, a});
        wreg(1, d);
        global_irq_enable <= 1'h0;
        wreg(2, 8'h08);
        wreg(2, 8'h0c);
        wait_idle();
        chk(ctrl_rdata, 8'h08);
        chk({7'h00, nvm_done_irq_flag}, 8'h01);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        wreg(0, {2'h0, a});
        wreg(2, 8'h02);
        exp_q.push_back(e);
        wreg(2, 8'h03);
        wait_idle();
    endtask
    ////////////////////////////////////////////////////////////////
    // a result is a read whose trigger bit has just fallen
    always @(posedge sys_clk)
    begin
        seen_go <= ctrl_rdata[0];
        if (seen_go === 1'h1 && ctrl_rdata[0] === 1'h0 && exp_q.size() > 0)
            chk(byte_rdata, exp_q.pop_front());
    end
    initial
    begin
        void'($urandom(32'ha82f));
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        settle();
        chk(ctrl_rdata, 8'h00);
        chk(index_rdata, 8'h00);
        wreg(0, 8'hff);
        settle();
        chk(index_rdata, 8'h3f);
        wreg(2, 8'h04);
        settle();
        chk(ctrl_rdata, 8'h00);
        wreg(2, 8'h01);
        settle();
        chk(ctrl_rdata, 8'h00);
        ptr_high <= 8'h00;
        wreg(2, 8'h0a);
        ptr_high <= 8'h01;
        settle();
        chk(ctrl_rdata, 8'h00);
        $display("test refusals done");
        for (int i = 0; i < 4; i++)
        begin
            adr[i] = {2'(i), (i == 3) ? 4'hf : 4'($urandom)};
            mem[i] = 8'($urandom);
            wr(adr[i], mem[i]);
        end
        wreg(2, 8'h00);
        $display("test writes done");
        stack_full <= 1'h1;
        nvm_done_irq_enable <= 1'h1;
        global_irq_enable <= 1'h1;
        settle();
        chk({7'h00, irq_request}, 8'h00);
        chk({7'h00, nvm_done_irq_flag}, 8'h01);
        stack_full <= 1'h0;
        #1;
        chk({7'h00, irq_request}, 8'h01);
        settle();
        chk({7'h00, nvm_done_irq_flag}, 8'h00);
        nvm_done_irq_enable <= 1'h0;
        $display("test interrupt done");
        for (int i = 3; i >= 0; i--)
            rd(adr[i], mem[i]);
        $display("test reads done");
        wreg(0, {2'h0, adr[1]});
        wreg(2, 8'h02);
        exp_q.push_back(mem[0]);
        wreg(2, 8'h03);
        low_power_entry <= 1'h1;
        @(posedge sys_clk);
        low_power_entry <= 1'h0;
        wait_idle();
        settle();
        chk(8'(exp_q.size()), 8'h00);
        $display("test abort done");
        tally_and_finish();
    end
endmodule
